// *** rtl/sxcr_pkg.sv ***
/*
 * constants, field layouts and state types of the transfer count, target id,
 * selector id and interrupt cause register bank.
 * assumes a 32-bit classic wishbone slave port and a 20 mhz clock.
 */
package sxcr_pkg;
    // register byte offsets
    localparam logic [3:0] OFF_COUNT = 4'h0;
    localparam logic [3:0] OFF_TARGET = 4'h4;
    localparam logic [3:0] OFF_SELECTOR = 4'h8;
    localparam logic [3:0] OFF_CAUSE = 4'hC;

    // reset values
    localparam logic [23:0] RST_COUNT = 24'h000000;
    localparam logic [7:0] RST_TARGET = 8'h00;
    localparam logic [7:0] RST_SELECTOR = 8'h00;
    localparam logic [7:0] RST_CAUSE = 8'h00;

    // target_select_id fields
    localparam int TGT_ID_LSB = 0;
    localparam int TGT_TAG_LSB = 3;
    localparam int TGT_FEATURE_DISABLE = 5;
    localparam int TGT_EXPECTED_DIR = 6;
    localparam int TGT_CHAIN_SELECT = 7;

    // selector_id_and_response fields
    localparam int SEL_ID_LSB = 0;
    localparam int SEL_VALID = 3;
    localparam int SEL_PARITY_IGNORE = 5;
    localparam int SEL_ENABLE = 6;
    localparam int RESEL_ENABLE = 7;
    localparam logic [7:0] SEL_SW_MASK = 8'hE0;

    // tag message codes
    localparam logic [7:0] TAG_SIMPLE = 8'h20;
    localparam logic [7:0] TAG_HEAD = 8'h21;
    localparam logic [7:0] TAG_ORDERED = 8'h22;
    localparam logic [7:0] TAG_NONE = 8'h00;

    // interrupt groups and codes
    localparam logic [3:0] GRP_RESET = 4'h0;
    localparam logic [3:0] GRP_SUCCESS = 4'h1;
    localparam logic [3:0] GRP_PAUSED = 4'h2;
    localparam logic [3:0] GRP_ERROR = 4'h4;
    localparam logic [3:0] GRP_BUS_EVENT = 4'h8;
    localparam logic [3:0] QUAL_SEND_RECV_DONE = 4'h3;
    localparam logic [3:0] QUAL_XINFO_DONE = 4'h8;
    localparam logic [3:0] QUAL_DIR_ERROR = 4'h8;

    typedef enum logic [1:0] {
        SXCR_CMD_SEND_RECV = 2'b00,
        SXCR_CMD_XFER_INFO = 2'b01,
        SXCR_CMD_COMBINATION = 2'b10
    } sxcr_cmd_t;

    typedef enum logic [0:0] {
        SXCR_CNT_IDLE = 1'b0,
        SXCR_CNT_RUN = 1'b1
    } sxcr_cnt_state_t;
endpackage : sxcr_pkg

// *** rtl/sxcr_regs.sv ***
/*
 * transfer counter, target id, selector id and interrupt cause registers.
 * assumes a classic wishbone master on clk, a command sequencer on the same
 * clock driving the start, byte, halt and event strobes, and scsi phase pins
 * that arrive active low and unsynchronised.
 */
`timescale 1ns/1ns
// Contract
// R1 - start loads preset, bytes decrement, zero interrupts; no interrupt at zero for combination commands
// R2 - zero preset or single byte: one byte
// R3 - combination: count is data-phase byte count
// R4 - successful non-single transfer leaves count zero
// R5 - halt leaves count of bytes not moved
// R6 - low three bits give target bus id
// R7 - tag bits select and record tag message
// R8 - either tag bit sends simple tag reselecting
// R9 - feature disable stops direction check, auto link
// R10 - expected direction mismatch raises phase error
// R11 - chain select picks status or disconnect next
// R12 - selector id meaningful only while valid set
// R13 - valid set when other device drove id
// R14 - parity ignore bit skips selection parity
// R15 - enable bits gate selection and reselection response
// R16 - interrupt raised, cause code readable
// R17 - cause code frozen until host reads
// R18 - upper nibble is interrupt group
// R19 - lower nibble is group qualifier
// R20 - phase field reflects msg, c/d, i/o
// R21 - status read drops interrupt request
module sxcr_regs (
    input wire logic clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic cmd_start,
    input wire logic [1:0] cmd_kind,
    input wire logic cmd_single_byte,
    input wire logic byte_moved,
    input wire logic xfer_halt,
    input wire logic advanced_mode,
    input wire logic data_phase_enter,
    input wire logic tag_received,
    input wire logic [1:0] tag_received_sel,
    input wire logic sel_event,
    input wire logic sel_is_reselect,
    input wire logic [7:0] sel_bus_ids,
    input wire logic [2:0] own_id,
    input wire logic sel_parity_ok,
    input wire logic irq_event,
    input wire logic [7:0] irq_event_code,
    input wire logic msg_n,
    input wire logic cd_n,
    input wire logic io_n,
    output logic [2:0] target_id_bits,
    output logic [1:0] tag_message_select,
    output logic [7:0] tag_message_code,
    output logic send_simple_tag_after_identify,
    output logic direction_check_enable,
    output logic auto_link_enable,
    output logic chain_command_select,
    output logic data_phase_expected,
    output logic counter_busy,
    output logic selection_accepted,
    output logic [2:0] bus_phase_field,
    output logic host_interrupt_request
);
    logic [23:0] transfer_byte_count;
    logic [7:0] target_select_id;
    logic [7:0] selector_id_and_response;
    logic [7:0] interrupt_cause_code;
    logic [23:0] counter;
    sxcr_pkg::sxcr_cnt_state_t cnt_state;
    sxcr_pkg::sxcr_cmd_t run_kind;
    logic run_single;
    logic run_disabled;
    logic [2:0] phase_meta;
    logic [2:0] phase_sync;
    wire [2:0] phase_pins = {msg_n, cd_n, io_n};
    logic bus_take;
    logic status_read;
    logic xfer_done;
    logic dir_error;
    logic ev_valid;
    logic [7:0] ev_code;
    logic deferred_valid;
    logic [7:0] deferred_code;
    logic [7:0] next_selector;
    logic [7:0] other_ids;
    logic [7:0] wr_byte0;

    function automatic logic [7:0] sxcr_tag_code(input logic [1:0] sel);
        case (sel)
            2'b01: sxcr_tag_code = sxcr_pkg::TAG_SIMPLE;
            2'b10: sxcr_tag_code = sxcr_pkg::TAG_HEAD;
            2'b11: sxcr_tag_code = sxcr_pkg::TAG_ORDERED;
            default: sxcr_tag_code = sxcr_pkg::TAG_NONE;
        endcase
    endfunction : sxcr_tag_code

    function automatic logic [2:0] sxcr_encode_id(input logic [7:0] ids);
        sxcr_encode_id = 3'h0;
        for (int i = 0; i < 8; i++)
        begin
            if (ids[i])
            begin
                sxcr_encode_id = 3'(i);
            end
        end
    endfunction : sxcr_encode_id

    // phase pin synchronisers
    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : g_phase_sync
            always_ff @(posedge clk or posedge rst)
            begin
                if (rst)
                begin
                    phase_meta[g] <= 1'b1;
                    phase_sync[g] <= 1'b1;
                end
                else
                begin
                    phase_meta[g] <= phase_pins[g];
                    phase_sync[g] <= phase_meta[g];
                end
            end
        end
    endgenerate

    // wishbone request decode
    assign bus_take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign status_read = bus_take & ~wb_we_i & (wb_adr_i == sxcr_pkg::OFF_CAUSE);
    assign wr_byte0 = wb_dat_i[7:0];

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end
        else
        begin
            wb_ack_o <= bus_take;
            if (bus_take & ~wb_we_i)
            begin
                case (wb_adr_i)
                    sxcr_pkg::OFF_COUNT: wb_dat_o <= {8'h00, transfer_byte_count};
                    sxcr_pkg::OFF_TARGET: wb_dat_o <= {24'h000000, target_select_id};
                    sxcr_pkg::OFF_SELECTOR: wb_dat_o <= {24'h000000, selector_id_and_response};
                    sxcr_pkg::OFF_CAUSE: wb_dat_o <= {24'h000000, interrupt_cause_code};
                    default: wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end

    // transfer counter engine
    assign xfer_done = (cnt_state == sxcr_pkg::SXCR_CNT_RUN) & byte_moved
        & (run_disabled | (counter == 24'h000001)); // R1 R2
    assign counter_busy = (cnt_state == sxcr_pkg::SXCR_CNT_RUN);
    assign data_phase_expected = (transfer_byte_count != 24'h000000); // R3

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_state <= sxcr_pkg::SXCR_CNT_IDLE;
            counter <= sxcr_pkg::RST_COUNT;
            run_kind <= sxcr_pkg::SXCR_CMD_SEND_RECV;
            run_single <= 1'b0;
            run_disabled <= 1'b0;
        end
        else if (cmd_start)
        begin
            cnt_state <= sxcr_pkg::SXCR_CNT_RUN;
            counter <= transfer_byte_count; // R1 R3
            run_kind <= sxcr_pkg::sxcr_cmd_t'(cmd_kind);
            run_single <= cmd_single_byte;
            run_disabled <= cmd_single_byte | (transfer_byte_count == 24'h000000); // R2
        end
        else
        begin
            case (cnt_state)
                sxcr_pkg::SXCR_CNT_RUN:
                begin
                    if (xfer_halt)
                    begin
                        cnt_state <= sxcr_pkg::SXCR_CNT_IDLE;
                    end
                    else if (byte_moved)
                    begin
                        if (!run_disabled)
                        begin
                            counter <= counter - 24'h000001; // R1
                        end
                        if (xfer_done)
                        begin
                            cnt_state <= sxcr_pkg::SXCR_CNT_IDLE;
                        end
                    end
                end
                default: cnt_state <= sxcr_pkg::SXCR_CNT_IDLE;
            endcase
        end
    end

    // transfer count register
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            transfer_byte_count <= sxcr_pkg::RST_COUNT;
        end
        else if (xfer_done & ~run_single)
        begin
            transfer_byte_count <= 24'h000000; // R4
        end
        else if (counter_busy & xfer_halt)
        begin
            transfer_byte_count <= counter; // R5
        end
        else if (bus_take & wb_we_i & (wb_adr_i == sxcr_pkg::OFF_COUNT))
        begin
            for (int b = 0; b < 3; b++)
            begin
                if (wb_sel_i[b])
                begin
                    transfer_byte_count[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
                end
            end
        end
    end

    // target id register, tag field also recorded by hardware
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            target_select_id <= sxcr_pkg::RST_TARGET;
        end
        else
        begin
            if (bus_take & wb_we_i & wb_sel_i[0] & (wb_adr_i == sxcr_pkg::OFF_TARGET))
            begin
                target_select_id <= wr_byte0;
            end
            if (tag_received)
            begin
                target_select_id[sxcr_pkg::TGT_TAG_LSB +: 2] <= tag_received_sel; // R7
            end
        end
    end

    assign target_id_bits = target_select_id[sxcr_pkg::TGT_ID_LSB +: 3]; // R6
    assign tag_message_select = target_select_id[sxcr_pkg::TGT_TAG_LSB +: 2];
    assign tag_message_code = sxcr_tag_code(tag_message_select); // R7
    assign send_simple_tag_after_identify = |tag_message_select; // R8
    assign direction_check_enable = advanced_mode
        & ~target_select_id[sxcr_pkg::TGT_FEATURE_DISABLE]; // R9
    assign auto_link_enable = ~target_select_id[sxcr_pkg::TGT_FEATURE_DISABLE]; // R9
    assign chain_command_select = target_select_id[sxcr_pkg::TGT_CHAIN_SELECT]; // R11
    assign dir_error = data_phase_enter & direction_check_enable
        & (target_select_id[sxcr_pkg::TGT_EXPECTED_DIR] != bus_phase_field[0]); // R10

    // selector id register
    assign other_ids = sel_bus_ids & ~(8'h01 << own_id);
    assign selection_accepted = sel_event
        & (sel_is_reselect ? selector_id_and_response[sxcr_pkg::RESEL_ENABLE]
                           : selector_id_and_response[sxcr_pkg::SEL_ENABLE]) // R15
        & (sel_parity_ok | selector_id_and_response[sxcr_pkg::SEL_PARITY_IGNORE]); // R14

    always_comb
    begin
        next_selector = selector_id_and_response;
        if (bus_take & wb_we_i & wb_sel_i[0] & (wb_adr_i == sxcr_pkg::OFF_SELECTOR))
        begin
            next_selector = (wr_byte0 & sxcr_pkg::SEL_SW_MASK)
                | (selector_id_and_response & ~sxcr_pkg::SEL_SW_MASK);
        end
        if (selection_accepted)
        begin
            next_selector[sxcr_pkg::SEL_VALID] = |other_ids; // R13
            next_selector[sxcr_pkg::SEL_ID_LSB +: 3] =
                (|other_ids) ? sxcr_encode_id(other_ids) : 3'h0; // R12
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            selector_id_and_response <= sxcr_pkg::RST_SELECTOR;
        end
        else
        begin
            selector_id_and_response <= next_selector;
        end
    end

    // interrupt event merge and cause register
    always_comb
    begin
        ev_valid = 1'b1;
        ev_code = irq_event_code;
        if (irq_event)
        begin
            ev_code = irq_event_code; // R16
        end
        else if (dir_error)
        begin
            ev_code = {sxcr_pkg::GRP_ERROR, sxcr_pkg::QUAL_DIR_ERROR}; // R10 R18 R19
        end
        else if (xfer_done & (run_kind == sxcr_pkg::SXCR_CMD_XFER_INFO))
        begin
            ev_code = {sxcr_pkg::GRP_SUCCESS,
                sxcr_pkg::QUAL_XINFO_DONE | {1'b0, bus_phase_field}}; // R1 R19 R20
        end
        else if (xfer_done & (run_kind == sxcr_pkg::SXCR_CMD_SEND_RECV))
        begin
            ev_code = {sxcr_pkg::GRP_SUCCESS, sxcr_pkg::QUAL_SEND_RECV_DONE}; // R1 R18
        end
        else
        begin
            ev_valid = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            interrupt_cause_code <= sxcr_pkg::RST_CAUSE;
            host_interrupt_request <= 1'b1;
            deferred_valid <= 1'b0;
            deferred_code <= sxcr_pkg::RST_CAUSE;
        end
        else if (status_read)
        begin
            if (deferred_valid)
            begin
                interrupt_cause_code <= deferred_code;
                deferred_valid <= ev_valid;
                deferred_code <= ev_code;
            end
            else if (ev_valid)
            begin
                interrupt_cause_code <= ev_code; // R16
            end
            host_interrupt_request <= deferred_valid | ev_valid; // R21
        end
        else if (ev_valid & ~host_interrupt_request)
        begin
            interrupt_cause_code <= ev_code; // R16
            host_interrupt_request <= 1'b1;
        end
        else if (ev_valid & ~deferred_valid)
        begin
            deferred_valid <= 1'b1; // R17
            deferred_code <= ev_code;
        end
    end

    assign bus_phase_field = ~phase_sync; // R20

    // assertions
    sequence s_start_with_preset;
        cmd_start & ~cmd_single_byte & (transfer_byte_count != 24'h000000);
    endsequence
    sequence s_one_byte_disabled;
        counter_busy & run_disabled & byte_moved & ~xfer_halt & ~cmd_start;
    endsequence

    a_ack_single_cycle: assert property (@(posedge clk) disable iff (rst)
        bus_take |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not one cycle after request");

    a_count_load_preset: assert property (@(posedge clk) disable iff (rst) // R1
        s_start_with_preset |=> counter_busy && counter == $past(transfer_byte_count))
        else $error("counter did not load preset");

    a_single_byte_ends: assert property (@(posedge clk) disable iff (rst) // R2
        s_one_byte_disabled |=> !counter_busy)
        else $error("disabled counter did not finish after one byte");

    a_done_count_zero: assert property (@(posedge clk) disable iff (rst) // R4
        xfer_done & ~run_single & ~cmd_start |=> transfer_byte_count == 24'h000000)
        else $error("count not zero after transfer");

    a_halt_keeps_rest: assert property (@(posedge clk) disable iff (rst) // R5
        counter_busy & xfer_halt & ~xfer_done & ~cmd_start
        |=> transfer_byte_count == $past(counter))
        else $error("count not left at bytes not moved");

    a_cause_held_frozen: assert property (@(posedge clk) disable iff (rst) // R17
        host_interrupt_request & ~status_read |=> $stable(interrupt_cause_code))
        else $error("cause code changed while pending");

    a_read_drops_irq: assert property (@(posedge clk) disable iff (rst) // R21
        status_read & ~ev_valid & ~deferred_valid |=> !host_interrupt_request)
        else $error("status read did not drop interrupt");

    a_dir_error_irq: assert property (@(posedge clk) disable iff (rst) // R10
        dir_error & ~irq_event & ~host_interrupt_request
        |=> host_interrupt_request && interrupt_cause_code[7:4] == sxcr_pkg::GRP_ERROR)
        else $error("direction mismatch gave no error interrupt");

    a_selector_valid_set: assert property (@(posedge clk) disable iff (rst) // R13
        selection_accepted |=> selector_id_and_response[sxcr_pkg::SEL_VALID]
            == $past(|other_ids))
        else $error("selector valid bit wrong");

    a_gate_disabled_sel: assert property (@(posedge clk) disable iff (rst) // R15
        sel_event & ~sel_is_reselect & ~selector_id_and_response[sxcr_pkg::SEL_ENABLE]
        |-> !selection_accepted)
        else $error("selection answered while disabled");
endmodule : sxcr_regs

// *** sim/sxcr_far_model.sv ***
/*
 * far side model: moves a burst of bytes on the scsi bus at a chosen pace
 * and drives the active-low phase pins.
 * assumes the bench clock and the bench reset.
 */
`timescale 1ns/1ns
module sxcr_far_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic go,
    input wire logic [7:0] n_bytes,
    input wire logic [3:0] gap,
    input wire logic [2:0] phase,
    output logic byte_moved,
    output logic busy,
    output logic msg_n,
    output logic cd_n,
    output logic io_n
);
    logic [7:0] left;
    logic [3:0] pace;
    // a one in phase means asserted, so the pin is low
    assign {msg_n, cd_n, io_n} = ~phase;
    assign busy = (left != 8'h00);
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            left <= 8'h00;
            pace <= 4'h0;
            byte_moved <= 1'b0;
        end
        else if (go)
        begin
            left <= n_bytes;
            pace <= gap;
            byte_moved <= 1'b0;
        end
        else if (busy && pace == 4'h0)
        begin
            left <= left - 8'h01;
            pace <= gap;
            byte_moved <= 1'b1;
        end
        else
        begin
            pace <= busy ? pace - 4'h1 : pace;
            byte_moved <= 1'b0;
        end
    end
endmodule : sxcr_far_model

// *** sim/testbench.sv ***
/*
 * self-checking bench for the register bank: wishbone host tasks, command
 * and selection strobes, far side byte model.
 * assumes a 20 mhz clock and the register offsets of the package.
 */
`timescale 1ns/1ns
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; \
    $display("mismatch t=%0t got %0h exp %0h", $time, (g), (e)); end end
module testbench;
    logic clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [3:0] wb_adr_i, wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic cmd_start, cmd_single_byte, byte_moved, xfer_halt, advanced_mode;
    logic data_phase_enter, tag_received, sel_event, sel_is_reselect;
    logic sel_parity_ok, irq_event, msg_n, cd_n, io_n, go, far_busy;
    logic [1:0] cmd_kind, tag_received_sel, tag_message_select;
    logic [7:0] sel_bus_ids, irq_event_code, tag_message_code, n_bytes;
    logic [2:0] own_id, phase, target_id_bits, bus_phase_field;
    logic [3:0] gap;
    logic send_simple_tag_after_identify, direction_check_enable, auto_link_enable;
    logic chain_command_select, data_phase_expected, counter_busy;
    logic selection_accepted, host_interrupt_request;
    int failures = 0;
    int n_checks = 0;
    int moved = 0;
    int base = 0;

    sxcr_regs u_dut (.clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .cmd_start, .cmd_kind, .cmd_single_byte,
        .byte_moved, .xfer_halt, .advanced_mode, .data_phase_enter, .tag_received,
        .tag_received_sel, .sel_event, .sel_is_reselect, .sel_bus_ids, .own_id,
        .sel_parity_ok, .irq_event, .irq_event_code, .msg_n, .cd_n, .io_n,
        .target_id_bits, .tag_message_select, .tag_message_code,
        .send_simple_tag_after_identify, .direction_check_enable, .auto_link_enable,
        .chain_command_select, .data_phase_expected, .counter_busy,
        .selection_accepted, .bus_phase_field, .host_interrupt_request);
    sxcr_far_model u_far (.clk, .rst, .go, .n_bytes, .gap, .phase, .byte_moved,
        .busy(far_busy), .msg_n, .cd_n, .io_n);

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk)
        if (byte_moved === 1'b1)
            moved++;

    task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] wd,
        output logic [31:0] rd);
        int n;
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= wd;
        for (n = 0; n == 0 || (n < 20 && wb_ack_o !== 1'b1); n++)
            @(posedge clk);
        `CHK(wb_ack_o, 1'b1)
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask : wb

    task automatic wr(input logic [3:0] adr, input logic [31:0] d);
        logic [31:0] r;
        wb(1'b1, adr, d, r);
    endtask : wr

    task automatic rdc(input logic [3:0] adr, input logic [31:0] e);
        logic [31:0] r;
        wb(1'b0, adr, 32'h00000000, r);
        `CHK(r, e)
    endtask : rdc

    task automatic wait_irq;
        for (int n = 0; n < 200 && host_interrupt_request !== 1'b1; n++)
            @(negedge clk);
        `CHK(host_interrupt_request, 1'b1)
    endtask : wait_irq

    task automatic run(input logic [1:0] kind, input logic single,
        input logic [23:0] preset, input logic [7:0] nb, input logic [3:0] g);
        wr(4'h0, {8'h00, preset});
        cmd_start <= 1'b1;
        cmd_kind <= kind;
        cmd_single_byte <= single;
        base = moved;
        @(posedge clk);
        cmd_start <= 1'b0;
        go <= 1'b1;
        n_bytes <= nb;
        gap <= g;
        @(posedge clk);
        go <= 1'b0;
    endtask : run

    task automatic t_reset;
        @(negedge clk);
        `CHK(host_interrupt_request, 1'b1)
        rdc(4'hC, {24'h000000, sxcr_pkg::GRP_RESET, 4'h0});
        @(negedge clk);
        `CHK(host_interrupt_request, 1'b0)
        rdc(4'h0, 32'h00000000);
        rdc(4'h4, 32'h00000000);
        rdc(4'h8, 32'h00000000);
        wr(4'h6, 32'hFFFFFFFF);
        rdc(4'h6, 32'h00000000);
        wr(4'hC, 32'h000000FF);
        rdc(4'hC, 32'h00000000);
        $display("test reset done");
    endtask : t_reset

    task automatic t_target;
        logic [7:0] codes [4] = '{8'h00, 8'h20, 8'h21, 8'h22};
        for (int t = 0; t < 4; t++)
        begin
            wr(4'h4, {24'h000000, 3'b100, t[1:0], 3'h5});
            @(negedge clk);
            `CHK(target_id_bits, 3'h5)
            `CHK({tag_message_select, tag_message_code}, {t[1:0], codes[t]})
            `CHK(send_simple_tag_after_identify, (t != 0))
            `CHK(chain_command_select, 1'b1)
        end
        advanced_mode <= 1'b1;
        wr(4'h4, 32'h00000020);
        @(negedge clk);
        `CHK({direction_check_enable, auto_link_enable}, 2'b00)
        wr(4'h4, 32'h00000000);
        @(negedge clk);
        `CHK({direction_check_enable, auto_link_enable}, 2'b11)
        @(posedge clk);
        tag_received <= 1'b1;
        tag_received_sel <= 2'b10;
        @(posedge clk);
        tag_received <= 1'b0;
        rdc(4'h4, 32'h00000010);
        $display("test target done");
    endtask : t_target

    task automatic t_count;
        @(posedge clk);
        phase <= 3'b110;
        run(sxcr_pkg::SXCR_CMD_SEND_RECV, 1'b0, 24'h000003, 8'h03, 4'h2);
        wait_irq;
        `CHK(moved - base, 3)
        rdc(4'h0, 32'h00000000);
        rdc(4'hC, 32'h00000013);
        run(sxcr_pkg::SXCR_CMD_XFER_INFO, 1'b0, 24'h000002, 8'h02, 4'h0);
        wait_irq;
        rdc(4'hC, 32'h0000001E);
        for (int i = 0; i < 2; i++)
        begin
            run(sxcr_pkg::SXCR_CMD_SEND_RECV, i[0], i ? 24'h000005 : 24'h000000,
                8'h03, 4'h3);
            wait_irq;
            `CHK(moved - base, 1)
            repeat (16) @(posedge clk);
            rdc(4'hC, 32'h00000013);
        end
        run(sxcr_pkg::SXCR_CMD_SEND_RECV, 1'b0, 24'h00000A, 8'h04, 4'h0);
        repeat (8) @(posedge clk);
        xfer_halt <= 1'b1;
        @(posedge clk);
        xfer_halt <= 1'b0;
        rdc(4'h0, 32'h00000006);
        wr(4'h0, 32'h00000000);
        @(negedge clk);
        `CHK(data_phase_expected, 1'b0)
        run(sxcr_pkg::SXCR_CMD_COMBINATION, 1'b0, 24'h000007, 8'h00, 4'h0);
        @(negedge clk);
        `CHK({data_phase_expected, counter_busy}, 2'b11)
        repeat (6) @(negedge clk);
        `CHK(host_interrupt_request, 1'b0)
        $display("test count done");
    endtask : t_count

    task automatic sel_case(input logic [7:0] sreg, input logic [7:0] ids,
        input logic resel, input logic par, input logic acc, input logic [7:0] rb);
        wr(4'h8, {24'h000000, sreg});
        sel_event <= 1'b1;
        sel_bus_ids <= ids;
        sel_is_reselect <= resel;
        sel_parity_ok <= par;
        @(negedge clk);
        `CHK(selection_accepted, acc)
        @(posedge clk);
        sel_event <= 1'b0;
        rdc(4'h8, {24'h000000, rb});
    endtask : sel_case

    task automatic t_select;
        sel_case(8'hC0, 8'h88, 1'b0, 1'b1, 1'b1, 8'hCB);
        sel_case(8'hC0, 8'h80, 1'b0, 1'b1, 1'b1, 8'hC0);
        sel_case(8'h80, 8'h88, 1'b0, 1'b1, 1'b0, 8'h80);
        sel_case(8'h40, 8'h88, 1'b1, 1'b1, 1'b0, 8'h40);
        sel_case(8'hC0, 8'h88, 1'b0, 1'b0, 1'b0, 8'hC0);
        sel_case(8'hE0, 8'h88, 1'b0, 1'b0, 1'b1, 8'hEB);
        sel_case(8'h80, 8'h88, 1'b1, 1'b1, 1'b1, 8'h8B);
        $display("test select done");
    endtask : t_select

    task automatic t_phase;
        for (int p = 0; p < 8; p++)
        begin
            @(posedge clk);
            phase <= p[2:0];
            repeat (3) @(posedge clk);
            @(negedge clk);
            `CHK(bus_phase_field, p[2:0])
        end
        $display("test phase done");
    endtask : t_phase

    task automatic t_dir;
        @(posedge clk);
        phase <= 3'b000;
        for (int i = 0; i < 2; i++)
        begin
            wr(4'h4, i ? 32'h00000060 : 32'h00000040);
            repeat (3) @(posedge clk);
            data_phase_enter <= 1'b1;
            @(posedge clk);
            data_phase_enter <= 1'b0;
            if (i == 0)
            begin
                wait_irq;
                rdc(4'hC, 32'h00000048);
            end
        end
        repeat (4) @(negedge clk);
        `CHK(host_interrupt_request, 1'b0)
        $display("test direction done");
    endtask : t_dir

    task automatic t_hold;
        @(posedge clk);
        irq_event <= 1'b1;
        irq_event_code <= 8'h85;
        @(posedge clk);
        irq_event_code <= 8'h42;
        @(posedge clk);
        irq_event <= 1'b0;
        repeat (4) @(posedge clk);
        rdc(4'hC, 32'h00000085);
        wait_irq;
        rdc(4'hC, 32'h00000042);
        @(negedge clk);
        `CHK(host_interrupt_request, 1'b0)
        $display("test hold done");
    endtask : t_hold

    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : conclude

    initial
    begin
        {wb_cyc_i, wb_stb_i, wb_we_i, cmd_start, cmd_single_byte, xfer_halt} = 6'h00;
        {advanced_mode, data_phase_enter, tag_received, sel_event} = 4'h0;
        {sel_is_reselect, sel_parity_ok, irq_event, go} = 4'h0;
        {wb_adr_i, wb_dat_i, cmd_kind, tag_received_sel} = 40'h0000000000;
        {sel_bus_ids, irq_event_code, n_bytes, gap, phase} = 31'h00000000;
        wb_sel_i = 4'hF;
        own_id = 3'h7;
        rst = 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_target;
        t_count;
        t_select;
        t_phase;
        t_dir;
        t_hold;
        conclude;
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        failures++;
        $display("mismatch t=%0t watchdog expired", $time);
        conclude;
    end
endmodule : testbench
